// *** lrs_framer_model.sv ***
// System-side framer model driving transmit data once per line period
module lrs_framer_model (
  input wire logic pclk,
  input wire logic line_clk,
  input wire logic single,
  input wire logic zeros,
  output logic tx_positive_data,
  output logic tx_negative_data
);
  timeunit 1ns;
  timeprecision 1ns;

  logic lc_q = 1'b0;
  logic [3:0] cnt = 4'h0;
  logic [1:0] r;

  initial begin
    tx_positive_data = 1'b0;
    tx_negative_data = 1'b0;
  end

  // New symbol late in the period, so it is settled before the next rise
  always @(posedge pclk) begin
    lc_q <= line_clk;
    cnt <= (line_clk && !lc_q) ? 4'h1 : cnt + 4'h1;
    if (cnt == 4'h5) begin
      r = 2'($urandom);
      if (single) begin
        tx_positive_data <= r[0] & !zeros;
        tx_negative_data <= !tx_negative_data; // Unused pin keeps moving
      end else begin
        tx_positive_data <= r[0];
        tx_negative_data <= r[1] & !r[0];
      end
    end
  end
endmodule : lrs_framer_model

// *** lrs_pkg.sv ***
// Constants, field layouts and carrier types of the rate and rail select block
package lrs_pkg;

  // ---------------------------------------------------------------
  // Register map, byte addresses
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_INT_STATUS = 8'h08;
  localparam logic [7:0] OFF_INT_MASK = 8'h0C;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_RAIL = 0;
  localparam int CTRL_RATE = 1;
  localparam int CTRL_E3 = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int STAT_RAIL = 2;
  localparam int INT_CV = 0;
  localparam int INT_EXZ = 1;
  localparam logic [1:0] INT_RESET = 2'h0;

  // ---------------------------------------------------------------
  // Line code run lengths and synchroniser lanes
  // ---------------------------------------------------------------
  localparam logic [2:0] RUN_B3ZS = 3'h3;
  localparam logic [2:0] RUN_HDB3 = 3'h4;
  localparam int SY_CLK = 0;
  localparam int SY_TXP = 1;
  localparam int SY_TXN = 2;
  localparam int SY_RXP = 3;
  localparam int SY_RXN = 4;
  localparam int SY_N = 5;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    LRS_RATE_DS3 = 2'h0,
    LRS_RATE_STS1 = 2'h1,
    LRS_RATE_E3 = 2'h2
  } lrs_rate_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } lrs_rail_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } lrs_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } lrs_apb_rsp_t;

endpackage : lrs_pkg

// *** lrs_rate_and_rail_select.sv ***
// Per-channel rate and rail select with B3ZS/HDB3 coding and APB registers
//
// The address map and the APB interface to the registers are this design's own decisions.

// Overview of operation
// - Rate 0, E3 0: run DS3
// - Rate 1, E3 0: run STS-1
// - E3 1 overrides rate select: run E3
// - Single rail enables B3ZS/HDB3 coder both ways
// - Single rail takes transmit data from positive pin
// - Single rail delivers receive data on positive output
// - Single rail negative output flags violations
// - Dual rail bypasses encoder and decoder
// - Dual rail takes positive and negative transmit rails
// - Dual rail positive pulse: one-period positive output
// - Dual rail negative pulse: one-period negative output
module lrs_rate_and_rail_select #(
  parameter int ADDR_W = lrs_pkg::ADDR_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire lrs_pkg::lrs_apb_req_t apb_req,
  output lrs_pkg::lrs_apb_rsp_t apb_rsp,
  input wire logic line_clk,
  input wire logic tx_positive_data,
  input wire logic tx_negative_data,
  input wire lrs_pkg::lrs_rail_t rx_line_pair,
  output lrs_pkg::lrs_rail_t tx_line,
  output logic rx_positive_data,
  output logic rx_negative_or_violation,
  output lrs_pkg::lrs_rate_t line_rate,
  output logic irq
);
  import lrs_pkg::*;

  // ---------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------
  generate
    if (ADDR_W != lrs_pkg::ADDR_W) begin : g_bad_addr
      $error("ADDR_W must match the package address width");
    end
  endgenerate

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    lrs_rate_t rate;
    logic [1:0] int_status;
    logic [1:0] int_mask;
    logic [31:0] prdata;
    logic [SY_N-1:0] sync1;
    logic [SY_N-1:0] sync2;
    logic clk_prev;
    logic [3:0] enc_mark;
    logic [3:0] enc_viol;
    logic enc_parity;
    logic enc_last_pol;
    lrs_rail_t tx_out;
    logic [3:0] dec_data;
    logic dec_last_pol;
    logic [2:0] dec_zeros;
    logic rx_pos_out;
    logic rx_neg_out;
  } lrs_state_t;

  lrs_state_t st_reg;
  lrs_state_t st_next;
  logic [SY_N-1:0] pins_raw;
  logic edge_now;
  logic single_rail;
  logic hdb3;
  logic apb_setup;
  logic apb_access;
  logic addr_hit;

  // Raw pins, only ever read by the first synchroniser stage
  assign pins_raw = {rx_line_pair.neg, rx_line_pair.pos, tx_negative_data,
                     tx_positive_data, line_clk};

  // Line clock rising edge, found on the second stage and its follower
  assign edge_now = st_reg.sync2[SY_CLK] & ~st_reg.clk_prev;
  assign single_rail = st_reg.ctrl[CTRL_RAIL];
  assign hdb3 = (st_reg.rate == LRS_RATE_E3);

  // APB decode; zero wait states, so pready is constant high
  assign apb_setup = apb_req.psel & ~apb_req.penable;
  assign apb_access = apb_req.psel & apb_req.penable;
  assign addr_hit = (apb_req.paddr == OFF_CTRL) ||
                    (apb_req.paddr == OFF_STATUS) ||
                    (apb_req.paddr == OFF_INT_STATUS) ||
                    (apb_req.paddr == OFF_INT_MASK);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin : comb_next
    logic [7:0] ctl;
    logic [3:0] m;
    logic [3:0] v;
    logic pol;
    logic zrun;
    logic [3:0] d;
    logic mk;
    logic bpv;
    logic valid;
    logic cv;
    logic exz;
    ctl = 8'h00;
    m = 4'h0;
    v = 4'h0;
    pol = 1'b0;
    zrun = 1'b0;
    d = 4'h0;
    mk = 1'b0;
    bpv = 1'b0;
    valid = 1'b0;
    cv = 1'b0;
    exz = 1'b0;
    st_next = st_reg;

    // Synchronisers and edge follower
    st_next.sync1 = pins_raw;
    st_next.sync2 = st_reg.sync1;
    st_next.clk_prev = st_reg.sync2[SY_CLK];

    // Read data captured in the setup phase, unmapped reads give zero
    if (apb_setup) begin
      case (apb_req.paddr)
        OFF_CTRL: st_next.prdata = {24'h000000, st_reg.ctrl};
        OFF_STATUS: st_next.prdata = {29'h00000000, single_rail, st_reg.rate};
        OFF_INT_STATUS: st_next.prdata = {30'h00000000, st_reg.int_status};
        OFF_INT_MASK: st_next.prdata = {30'h00000000, st_reg.int_mask};
        default: st_next.prdata = 32'h00000000;
      endcase
    end

    // Writes land at the access edge; status clears by writing ones
    if (apb_access && apb_req.pwrite && addr_hit) begin
      case (apb_req.paddr)
        OFF_CTRL: st_next.ctrl = apb_req.pwdata[7:0];
        OFF_INT_STATUS: st_next.int_status = st_reg.int_status &
                                            ~apb_req.pwdata[1:0];
        OFF_INT_MASK: st_next.int_mask = apb_req.pwdata[1:0];
        default: st_next.ctrl = st_reg.ctrl;
      endcase
    end

    // Rate follows the control bits in the same cycle; E3 wins
    ctl = st_next.ctrl;
    if (ctl[CTRL_E3]) begin
      st_next.rate = LRS_RATE_E3;
    end else if (ctl[CTRL_RATE]) begin
      st_next.rate = LRS_RATE_STS1;
    end else begin
      st_next.rate = LRS_RATE_DS3;
    end

    // Line side moves only on a line clock edge
    if (edge_now) begin
      if (single_rail) begin
        // Encoder: four-bit delay line so a zero run can be rewritten
        m = {st_reg.enc_mark[2:0], st_reg.sync2[SY_TXP]};
        v = {st_reg.enc_viol[2:0], 1'b0};
        zrun = hdb3 ? (m == 4'h0) : (m[2:0] == 3'h0);
        if (zrun) begin
          m[0] = 1'b1;
          v[0] = 1'b1;
          // Even pulse count since last V needs a B pulse for balance
          if (!st_reg.enc_parity) begin
            if (hdb3) begin
              m[3] = 1'b1;
            end else begin
              m[2] = 1'b1;
            end
          end
          st_next.enc_parity = 1'b0;
        end else begin
          st_next.enc_parity = st_reg.enc_parity ^ m[0];
        end
        st_next.enc_mark = m;
        st_next.enc_viol = v;
        // V repeats the last polarity, every other mark alternates
        pol = st_reg.enc_viol[3] ? st_reg.enc_last_pol : ~st_reg.enc_last_pol;
        if (st_reg.enc_mark[3]) begin
          st_next.enc_last_pol = pol;
        end
        st_next.tx_out.pos = st_reg.enc_mark[3] & pol;
        st_next.tx_out.neg = st_reg.enc_mark[3] & ~pol;

        // Decoder: strip V and its B, flag what is not a substitution
        mk = st_reg.sync2[SY_RXP] | st_reg.sync2[SY_RXN];
        d = {st_reg.dec_data[2:0], mk};
        bpv = mk && (st_reg.sync2[SY_RXP] ^ st_reg.sync2[SY_RXN]) &&
              (st_reg.sync2[SY_RXP] == st_reg.dec_last_pol);
        valid = hdb3 ? (st_reg.dec_data[1:0] == 2'h0) : ~st_reg.dec_data[0];
        if (bpv) begin
          d[0] = 1'b0;
          if (hdb3) begin
            d[3] = 1'b0;
          end else begin
            d[2] = 1'b0;
          end
        end
        if (mk && (st_reg.sync2[SY_RXP] ^ st_reg.sync2[SY_RXN])) begin
          st_next.dec_last_pol = st_reg.sync2[SY_RXP];
        end
        // Both rails at once is never legal bipolar signalling
        cv = (bpv && !valid) ||
             (st_reg.sync2[SY_RXP] && st_reg.sync2[SY_RXN]);
        if (mk) begin
          st_next.dec_zeros = 3'h0;
        end else if (st_reg.dec_zeros != 3'h7) begin
          st_next.dec_zeros = st_reg.dec_zeros + 3'h1;
        end
        exz = !mk && ((st_reg.dec_zeros + 3'h1) ==
                      (hdb3 ? RUN_HDB3 : RUN_B3ZS));
        st_next.dec_data = d;
        st_next.rx_pos_out = st_reg.dec_data[3];
        st_next.rx_neg_out = cv | exz;
        // Set wins over a clear written in the same cycle
        st_next.int_status[INT_CV] = st_next.int_status[INT_CV] | cv;
        st_next.int_status[INT_EXZ] = st_next.int_status[INT_EXZ] | exz;
      end else begin
        // Dual rail: rails pass straight through, one line period each
        st_next.tx_out.pos = st_reg.sync2[SY_TXP];
        st_next.tx_out.neg = st_reg.sync2[SY_TXN];
        st_next.rx_pos_out = st_reg.sync2[SY_RXP];
        st_next.rx_neg_out = st_reg.sync2[SY_RXN];
        st_next.enc_mark = 4'h0;
        st_next.enc_viol = 4'h0;
        st_next.dec_data = 4'h0;
        st_next.dec_zeros = 3'h0;
      end
    end
  end : comb_next

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{ctrl: CTRL_RESET, rate: LRS_RATE_DS3,
                  int_status: INT_RESET, int_mask: INT_RESET,
                  default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign apb_rsp.prdata = st_reg.prdata;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = apb_access & ~addr_hit;
  assign tx_line = st_reg.tx_out;
  assign rx_positive_data = st_reg.rx_pos_out;
  assign rx_negative_or_violation = st_reg.rx_neg_out;
  assign line_rate = st_reg.rate;
  // Level interrupt while any unmasked sticky bit stands
  assign irq = |(st_reg.int_status & st_reg.int_mask);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_dual_edge;
    !single_rail && edge_now;
  endsequence

  sequence s_single_edge;
    single_rail && edge_now;
  endsequence

  a_rate_ds3_sel: assert property (
    (!st_reg.ctrl[CTRL_E3] && !st_reg.ctrl[CTRL_RATE]) |->
      line_rate == LRS_RATE_DS3)
    else $error("DS3 not selected for rate 0, E3 0");

  a_rate_sts1_sel: assert property (
    (!st_reg.ctrl[CTRL_E3] && st_reg.ctrl[CTRL_RATE]) |->
      line_rate == LRS_RATE_STS1)
    else $error("STS-1 not selected for rate 1, E3 0");

  a_rate_e3_wins: assert property (
    st_reg.ctrl[CTRL_E3] |-> line_rate == LRS_RATE_E3)
    else $error("E3 bit did not force E3 rate");

  a_dual_tx_pass: assert property (
    s_dual_edge |=> tx_line == {$past(st_reg.sync2[SY_TXP]),
                                $past(st_reg.sync2[SY_TXN])})
    else $error("Dual rail transmit rails not passed through");

  a_dual_rx_pos: assert property (
    s_dual_edge |=> rx_positive_data == $past(st_reg.sync2[SY_RXP]))
    else $error("Dual rail positive receive mismatch");

  a_dual_rx_neg: assert property (
    s_dual_edge |=>
      rx_negative_or_violation == $past(st_reg.sync2[SY_RXN]))
    else $error("Dual rail negative receive mismatch");

  a_rx_period_hold: assert property (
    !edge_now |=> $stable(rx_positive_data) &&
                  $stable(rx_negative_or_violation))
    else $error("Receive output changed between line edges");

  a_single_tx_one: assert property (
    s_single_edge |=> !(tx_line.pos && tx_line.neg))
    else $error("Encoder drove both transmit rails");

  a_single_both_cv: assert property (
    (s_single_edge ##0 (st_reg.sync2[SY_RXP] && st_reg.sync2[SY_RXN]))
      |=> rx_negative_or_violation && st_reg.int_status[INT_CV])
    else $error("Both rails high not flagged as violation");

endmodule : lrs_rate_and_rail_select

// *** test_lrs_rate_and_rail_select.sv ***
// Self-checking bench of the rate and rail select block
`define chk(nm, ex, got) begin samples_checked++; \
  if ((got) !== (ex)) begin n_fail++; \
  $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module test_lrs_rate_and_rail_select import lrs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic line_clk = 1'b0;
  logic single = 1'b0;
  logic zeros = 1'b0;
  lrs_apb_req_t req = '0;
  lrs_apb_rsp_t rsp;
  logic txp;
  logic txn;
  lrs_rail_t rxl = '0;
  lrs_rail_t tx_line;
  logic rxp;
  logic rxn;
  lrs_rate_t rate;
  logic irq;
  int n_fail = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic er;
  logic [7:0] v;
  lrs_rail_t o_tx, tx_at, rx_at, rx;
  logic o_p, o_n, d, pol;
  logic q[$];
  int pulses, zc;

  // ---------------------------------------------------------------
  // Clocks and instances
  // ---------------------------------------------------------------
  initial begin
    forever #50 pclk = ~pclk;
  end

  // Line clock offset so its edges never line up with pclk
  initial begin
    #237;
    forever #400 line_clk = ~line_clk;
  end

  lrs_rate_and_rail_select u_lrs_rate_and_rail_select (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .line_clk(line_clk), .tx_positive_data(txp), .tx_negative_data(txn),
    .rx_line_pair(rxl), .tx_line(tx_line), .rx_positive_data(rxp),
    .rx_negative_or_violation(rxn), .line_rate(rate), .irq(irq));

  lrs_framer_model u_lrs_framer_model (
    .pclk(pclk), .line_clk(line_clk), .single(single), .zeros(zeros),
    .tx_positive_data(txp), .tx_negative_data(txn));

  // ---------------------------------------------------------------
  // Tasks and expectations
  // ---------------------------------------------------------------
  function automatic lrs_rate_t exp_rate(input logic [7:0] c);
    return c[CTRL_E3] ? LRS_RATE_E3 :
      (c[CTRL_RATE] ? LRS_RATE_STS1 : LRS_RATE_DS3);
  endfunction : exp_rate

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    begin
      n = 0;
      @(posedge pclk);
      req <= '{1'b1, 1'b0, w, a, wd};
      @(posedge pclk);
      req.penable <= 1'b1;
      @(posedge pclk);
      while (rsp.pready !== 1'b1 && n < 20) begin
        n++;
        @(posedge pclk);
      end
      // A slave that never answers counts against the run
      if (n >= 20) begin
        n_fail++;
        $display("MISMATCH apb_pready exp 1 got %0h", rsp.pready);
      end
      rd = rsp.prdata;
      er = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(negedge pclk);
    end
  endtask : apb

  // Outputs are read mid-period; the next symbol goes out after that
  task automatic step(input lrs_rail_t nx);
    begin
      @(posedge line_clk);
      tx_at = {txp, txn};
      rx_at = rxl;
      repeat (5) @(posedge pclk);
      @(negedge pclk);
      o_tx = tx_line;
      o_p = rxp;
      o_n = rxn;
      @(posedge pclk);
      rxl <= nx;
    end
  endtask : step

  task complete_run;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
        $display("ALL CHECKS OK");
      end else begin
        $display("CHECKS NOT OK");
      end
      $finish;
    end
  endtask : complete_run

  // Watchdog well beyond the expected run length
  initial begin
    #2000000;
    n_fail++;
    complete_run;
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h41f1a443));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_CTRL, 32'h0);
    `chk("ctrl reset", 32'h0, rd)
    apb(1'b0, OFF_STATUS, 32'h0);
    `chk("status reset", 32'h0, rd)
    for (int i = 0; i < 8; i++) begin
      v = {5'($urandom), i[1:0], 1'b0};
      apb(1'b1, OFF_CTRL, {24'h0, v});
      apb(1'b0, OFF_CTRL, 32'h0);
      `chk("ctrl", {24'h0, v}, rd)
      `chk("line_rate", exp_rate(v), rate)
      apb(1'b0, OFF_STATUS, 32'h0);
      `chk("status", {30'h0, exp_rate(v)}, rd)
    end
    // Unmapped place: error, reads zero
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    `chk("pslverr", 1'b1, er)
    apb(1'b0, 8'h10, 32'h0);
    `chk("unmapped rd", 32'h0, rd)
    // Dual rail: rails pass straight through
    apb(1'b1, OFF_CTRL, 32'h0);
    for (int k = 0; k < 24; k++) begin
      rx = 2'($urandom);
      rx.neg = rx.neg & !rx.pos;
      step(rx);
      if (k > 0) begin
        `chk("tx_line", tx_at, o_tx)
        `chk("rx_pos", rx_at.pos, o_p)
        `chk("rx_neg", rx_at.neg, o_n)
      end
    end
    // Single rail: coded transmit of all zeros, AMI receive
    single <= 1'b1;
    zeros <= 1'b1;
    apb(1'b1, OFF_CTRL, 32'h1);
    pulses = 0;
    zc = 0;
    pol = 1'b0;
    for (int k = 0; k < 30; k++) begin
      d = (zc == 2) ? 1'b1 : 1'($urandom);
      zc = d ? 0 : zc + 1;
      pol = pol ^ d;
      step(d ? {pol, !pol} : 2'b00);
      q.push_back(rx_at.pos | rx_at.neg);
      pulses += (o_tx != 2'b00);
      if (q.size() > 6) begin
        `chk("rx data", q[$-4], o_p)
        `chk("flag", 1'b0, o_n)
        `chk("tx rails", 1'b0, &o_tx)
      end
    end
    `chk("coded pulses", 1'b1, pulses >= 8)
    // Violation, then a long zero run
    step(2'b11);
    step(2'b00);
    `chk("violation", 1'b1, o_n)
    repeat (5) step(2'b00);
    apb(1'b0, OFF_INT_STATUS, 32'h0);
    `chk("events", 32'h3, rd)
    `chk("irq masked", 1'b0, irq)
    // Dual rail stops new events before clearing
    apb(1'b1, OFF_CTRL, 32'h0);
    apb(1'b1, OFF_INT_MASK, 32'h2);
    `chk("irq on", 1'b1, irq)
    apb(1'b1, OFF_INT_STATUS, 32'h1);
    apb(1'b0, OFF_INT_STATUS, 32'h0);
    `chk("w1c one", 32'h2, rd)
    `chk("irq held", 1'b1, irq)
    apb(1'b1, OFF_INT_STATUS, 32'h2);
    `chk("irq off", 1'b0, irq)
    complete_run;
  end
endmodule : test_lrs_rate_and_rail_select
